//--- shared/gcr_pkg.sv
// global chip control register bank: offsets, field positions, defaults
// assumes nothing beyond a single clock domain using these constants
package gcr_pkg;
  // register offsets within the indexed configuration space
  localparam logic [7:0] GCR_OFF_SWRST = 8'h02;
  localparam logic [7:0] GCR_OFF_LDN = 8'h07;
  localparam logic [7:0] GCR_OFF_ID_HI = 8'h20;
  localparam logic [7:0] GCR_OFF_ID_LO = 8'h21;
  localparam logic [7:0] GCR_OFF_PWR = 8'h22;
  localparam logic [7:0] GCR_OFF_IPD = 8'h23;
  localparam logic [7:0] GCR_OFF_OPT = 8'h24;
  localparam logic [7:0] GCR_OFF_TRI = 8'h25;
  // values after reset and writable bit masks
  localparam logic [7:0] GCR_RST_LDN = 8'h00;
  localparam logic [7:0] GCR_RST_PWR = 8'hFF;
  localparam logic [7:0] GCR_RST_IPD = 8'h00;
  localparam logic [7:0] GCR_RST_OPT = 8'h40;
  localparam logic [7:0] GCR_RST_TRI = 8'h00;
  localparam logic [7:0] GCR_MSK_PWR = 8'h79;
  localparam logic [7:0] GCR_MSK_IPD = 8'h01;
  localparam logic [7:0] GCR_MSK_OPT = 8'hFA;
  localparam logic [7:0] GCR_MSK_TRI = 8'h39;
  // field positions
  localparam int GCR_B_SWRST = 0;
  localparam int GCR_B_HWMON = 6;
  localparam int GCR_B_SERB = 5;
  localparam int GCR_B_SERA = 4;
  localparam int GCR_B_PAR = 3;
  localparam int GCR_B_FDC = 0;
  localparam int GCR_B_IPD = 0;
  localparam int GCR_B_CPUFAN1 = 7;
  localparam int GCR_B_INPUT_CLOCK_RATE_SELECT = 6;
  localparam int GCR_B_AUXFAN = 5;
  localparam int GCR_B_SYSFAN = 4;
  localparam int GCR_B_CPUFAN0 = 3;
  localparam int GCR_B_KBC = 2;
  localparam int GCR_B_FLASH = 1;
  // configuration port keys and base addresses
  localparam logic [7:0] GCR_KEY_ENTER = 8'h87;
  localparam logic [7:0] GCR_KEY_EXIT = 8'hAA;
  localparam logic [15:0] GCR_PORT_BASE0 = 16'h002E;
  localparam logic [15:0] GCR_PORT_BASE1 = 16'h004E;
  localparam logic [7:0] GCR_RD_IDLE = 8'hFF;
  // clocks after reset release before straps are trusted
  localparam logic [1:0] GCR_STRAP_SETTLE = 2'h3;
  typedef enum logic [2:0] {
    GCR_LOCKED = 3'h1,
    GCR_KEY1 = 3'h2,
    GCR_OPEN = 3'h4
  } gcr_cfg_state_t;
endpackage

//--- shared/gcr_ctl_if.sv
// control signals shared between the register bank, strap capture and pin mux
// assumes all three sit on the same clock
`timescale 1ns/1ps
interface gcr_ctl_if;
  logic strap_kbc;
  logic strap_flash;
  logic strap_port_sel;
  logic strap_load;
  logic flash_en;
  logic chip_pd;
  modport strap (output strap_kbc, output strap_flash, output strap_port_sel,
    output strap_load);
  modport core (input strap_kbc, input strap_flash, input strap_port_sel,
    input strap_load, output flash_en, output chip_pd);
  modport mux (input flash_en, input chip_pd);
endinterface

//--- src/gcr_strap_capture.sv
// power-on strap synchroniser and latch
// assumes strap pins are static around reset release
`timescale 1ns/1ps
module gcr_strap_capture
  import gcr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] strap_pins,
  gcr_ctl_if.strap ctl
);
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] latch_q;
  logic [1:0] settle_q;
  logic load_q;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= strap_pins;
      sync2_q <= sync1_q;
    end
  end

  // wait for the synchroniser to fill, then latch once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_q <= 2'h0;
      load_q <= 1'b0;
      latch_q <= 3'h0;
    end else begin
      load_q <= 1'b0;
      if (settle_q != GCR_STRAP_SETTLE) begin
        settle_q <= settle_q + 2'h1;
        if (settle_q == GCR_STRAP_SETTLE - 2'h1) begin
          latch_q <= sync2_q;
          load_q <= 1'b1;
        end
      end
    end
  end

  assign ctl.strap_kbc = latch_q[0];
  assign ctl.strap_flash = latch_q[1];
  assign ctl.strap_port_sel = latch_q[2];
  assign ctl.strap_load = load_q;
endmodule // gcr_strap_capture

//--- src/gcr_pin_mux.sv
// shared pin routing between serial flash and gpio/fan/beeper functions
// assumes core-side sources are on clk; pad inputs are asynchronous
`timescale 1ns/1ps
module gcr_pin_mux (
  input wire logic clk,
  input wire logic nrst,
  gcr_ctl_if.mux ctl,
  input wire logic flash_sck,
  input wire logic flash_ce_n,
  input wire logic flash_dout,
  input wire logic beep,
  input wire logic gpio_23_out,
  input wire logic gpio_23_oe,
  input wire logic gpio_22_out,
  input wire logic gpio_22_oe,
  input wire logic pin2_in,
  input wire logic pin19_in,
  input wire logic pin58_in,
  output logic pin2_out,
  output logic pin2_oe,
  output logic pin19_out,
  output logic pin19_oe,
  output logic pin118_out,
  output logic pin118_oe,
  output logic gpio_23_in,
  output logic gpio_22_in,
  output logic aux_fan_tach_in,
  output logic flash_din
);
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {pin58_in, pin19_in, pin2_in};
      sync2_q <= sync1_q;
    end
  end

  // outputs float during whole-chip power down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin2_out <= 1'b0;
      pin2_oe <= 1'b0;
      pin19_out <= 1'b0;
      pin19_oe <= 1'b0;
      pin118_out <= 1'b0;
      pin118_oe <= 1'b0;
    end else if (ctl.flash_en) begin
      pin2_out <= flash_sck;
      pin2_oe <= !ctl.chip_pd;
      pin19_out <= flash_ce_n;
      pin19_oe <= !ctl.chip_pd;
      pin118_out <= flash_dout;
      pin118_oe <= !ctl.chip_pd;
    end else begin
      pin2_out <= gpio_23_out;
      pin2_oe <= gpio_23_oe && !ctl.chip_pd;
      pin19_out <= gpio_22_out;
      pin19_oe <= gpio_22_oe && !ctl.chip_pd;
      pin118_out <= beep;
      pin118_oe <= !ctl.chip_pd;
    end
  end

  // unselected functions see a quiet zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpio_23_in <= 1'b0;
      gpio_22_in <= 1'b0;
      aux_fan_tach_in <= 1'b0;
      flash_din <= 1'b0;
    end else begin
      gpio_23_in <= !ctl.flash_en && sync2_q[0];
      gpio_22_in <= !ctl.flash_en && sync2_q[1];
      aux_fan_tach_in <= !ctl.flash_en && sync2_q[2];
      flash_din <= ctl.flash_en && sync2_q[2];
    end
  end
endmodule // gcr_pin_mux

//--- src/gcr_regs.sv
// global chip control registers behind an indexed configuration port
// assumes io_* strobes are single-cycle and synchronous to clk
// Summary of operation
// - writing one to bit 0 of the software reset register resets the chip
// - 8-bit logical device number, read/write, zero after reset
// - two read-only identity bytes; low nibble of low byte is revision
// - power-down register defaults all ones; zero powers a function down
// - immediate power-down bit, zero after reset, powers the whole chip down
// - option bit 7 picks cpu fan 1 drive: zero push-pull, one open-drain
// - option bit 5 picks aux fan drive: zero push-pull, one open-drain
// - option bit 4 picks system fan drive: zero open-drain, one push-pull
// - option bit 3 picks cpu fan 0 drive: zero open-drain, one push-pull
// - option bit 6 gives input clock rate: zero 24 MHz, one 48 MHz
// - option bit 2 is read-only keyboard controller enable from strap
// - option bit 1 loads serial flash enable from strap, stays writable
// - flash enable routes four shared pins to flash or gpio/fan/beeper
// - tri-state register, zero after reset, bits 5, 4, 3 and 0
`timescale 1ns/1ps
module gcr_regs
  import gcr_pkg::*;
#(
  parameter logic [7:0] ID_HIGH = 8'h5A, // arbitrary identity value
  parameter logic [3:0] ID_FAMILY = 4'h3, // arbitrary identity value
  parameter logic [3:0] ID_REVISION = 4'h1 // arbitrary revision value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  input wire logic strap_kbc_pin,
  input wire logic strap_flash_pin,
  input wire logic strap_port_sel_pin,
  output logic soft_reset,
  output logic [7:0] ldn,
  output logic hw_monitor_pwr,
  output logic serial_port_b_pwr,
  output logic serial_port_a_pwr,
  output logic parallel_port_pwr,
  output logic floppy_controller_pwr,
  output logic immediate_power_down,
  output logic cpu_fan_drive_1_od,
  output logic aux_fan_drive_od,
  output logic system_fan_drive_pp,
  output logic cpu_fan_drive_0_pp,
  output logic input_clock_rate_select,
  output logic keyboard_controller_en,
  output logic serial_flash_en,
  output logic config_port_select,
  output logic serial_b_hiz,
  output logic serial_a_hiz,
  output logic parallel_hiz,
  output logic floppy_hiz,
  input wire logic flash_sck,
  input wire logic flash_ce_n,
  input wire logic flash_dout,
  input wire logic beep,
  input wire logic gpio_23_out,
  input wire logic gpio_23_oe,
  input wire logic gpio_22_out,
  input wire logic gpio_22_oe,
  output logic gpio_23_in,
  output logic gpio_22_in,
  output logic aux_fan_tach_in,
  output logic flash_din,
  input wire logic pin2_in,
  output logic pin2_out,
  output logic pin2_oe,
  input wire logic pin19_in,
  output logic pin19_out,
  output logic pin19_oe,
  input wire logic pin58_in,
  output logic pin118_out,
  output logic pin118_oe
);
  import gcr_pkg::*;

  gcr_ctl_if ctl ();

  gcr_cfg_state_t state_q;
  logic [7:0] index_q;
  logic [7:0] ldn_q;
  logic [7:0] pwr_q;
  logic [7:0] ipd_q;
  logic [7:0] opt_q;
  logic [7:0] tri_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic swrst_q;
  logic [15:0] base;
  logic idx_hit;
  logic dat_hit;
  logic reg_wr;
  logic [7:0] opt_view;

  // matches an i/o address against one port of the pair
  function automatic logic port_hit(input logic [15:0] a, input logic [15:0] p);
    port_hit = (a == p);
  endfunction

  // merge new data into the writable bits only, reserved bits hold
  function automatic logic [7:0] merge(input logic [7:0] old,
    input logic [7:0] nw, input logic [7:0] msk);
    merge = (old & ~msk) | (nw & msk);
  endfunction

  gcr_strap_capture u_strap (
    .clk(clk),
    .nrst(nrst),
    .strap_pins({strap_port_sel_pin, strap_flash_pin, strap_kbc_pin}),
    .ctl(ctl.strap)
  );

  gcr_pin_mux u_mux (
    .clk(clk),
    .nrst(nrst),
    .ctl(ctl.mux),
    .flash_sck(flash_sck),
    .flash_ce_n(flash_ce_n),
    .flash_dout(flash_dout),
    .beep(beep),
    .gpio_23_out(gpio_23_out),
    .gpio_23_oe(gpio_23_oe),
    .gpio_22_out(gpio_22_out),
    .gpio_22_oe(gpio_22_oe),
    .pin2_in(pin2_in),
    .pin19_in(pin19_in),
    .pin58_in(pin58_in),
    .pin2_out(pin2_out),
    .pin2_oe(pin2_oe),
    .pin19_out(pin19_out),
    .pin19_oe(pin19_oe),
    .pin118_out(pin118_out),
    .pin118_oe(pin118_oe),
    .gpio_23_in(gpio_23_in),
    .gpio_22_in(gpio_22_in),
    .aux_fan_tach_in(aux_fan_tach_in),
    .flash_din(flash_din)
  );

  // port pair location follows the strap; data port sits at base + 1
  assign base = ctl.strap_port_sel ? GCR_PORT_BASE1 : GCR_PORT_BASE0;
  assign idx_hit = port_hit(io_addr, base);
  assign dat_hit = port_hit(io_addr, base + 16'h0001);
  assign reg_wr = io_wr && dat_hit && (state_q == GCR_OPEN);
  assign ctl.flash_en = opt_q[GCR_B_FLASH];
  assign ctl.chip_pd = ipd_q[GCR_B_IPD];

  // unlock sequence: two back-to-back entry keys open, exit key closes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= GCR_LOCKED;
    end else if (io_wr && idx_hit) begin
      case (state_q)
        GCR_LOCKED: begin
          if (io_wdata == GCR_KEY_ENTER) state_q <= GCR_KEY1;
        end
        GCR_KEY1: begin
          state_q <= (io_wdata == GCR_KEY_ENTER) ? GCR_OPEN : GCR_LOCKED;
        end
        GCR_OPEN: begin
          if (io_wdata == GCR_KEY_EXIT) state_q <= GCR_LOCKED;
        end
        default: begin
          state_q <= GCR_LOCKED;
        end
      endcase
    end
  end

  // index register only moves while the port is open
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      index_q <= 8'h00;
    end else if (io_wr && idx_hit && state_q == GCR_OPEN && io_wdata != GCR_KEY_EXIT) begin
      index_q <= io_wdata;
    end
  end

  // software reset: single pulse, never latched, so it can fire again
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      swrst_q <= 1'b0;
    end else begin
      swrst_q <= reg_wr && index_q == GCR_OFF_SWRST && io_wdata[GCR_B_SWRST];
    end
  end

  // logical device number; soft reset returns it to default
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ldn_q <= GCR_RST_LDN;
    end else if (swrst_q) begin
      ldn_q <= GCR_RST_LDN;
    end else if (reg_wr && index_q == GCR_OFF_LDN) begin
      ldn_q <= io_wdata;
    end
  end

  // per-function power down, active low per bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_q <= GCR_RST_PWR;
    end else if (swrst_q) begin
      pwr_q <= GCR_RST_PWR;
    end else if (reg_wr && index_q == GCR_OFF_PWR) begin
      pwr_q <= merge(pwr_q, io_wdata, GCR_MSK_PWR);
    end
  end

  // immediate whole-chip power down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ipd_q <= GCR_RST_IPD;
    end else if (swrst_q) begin
      ipd_q <= GCR_RST_IPD;
    end else if (reg_wr && index_q == GCR_OFF_IPD) begin
      ipd_q <= merge(ipd_q, io_wdata, GCR_MSK_IPD);
    end
  end

  // global option: flash enable reloads from its strap on hardware and soft reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opt_q <= GCR_RST_OPT;
    end else if (ctl.strap_load || swrst_q) begin
      opt_q <= GCR_RST_OPT;
      opt_q[GCR_B_FLASH] <= ctl.strap_flash;
    end else if (reg_wr && index_q == GCR_OFF_OPT) begin
      opt_q <= merge(opt_q, io_wdata, GCR_MSK_OPT);
    end
  end

  // interface tri-state controls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tri_q <= GCR_RST_TRI;
    end else if (swrst_q) begin
      tri_q <= GCR_RST_TRI;
    end else if (reg_wr && index_q == GCR_OFF_TRI) begin
      tri_q <= merge(tri_q, io_wdata, GCR_MSK_TRI);
    end
  end

  // keyboard enable bit is the strap itself; writes cannot reach it
  always_comb begin
    opt_view = opt_q;
    opt_view[GCR_B_KBC] = ctl.strap_kbc;
  end

  // read path: one-cycle answer; a locked port reads as idle bus
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= io_rd && (idx_hit || dat_hit);
      if (io_rd && state_q != GCR_OPEN) begin
        rdata_q <= GCR_RD_IDLE;
      end else if (io_rd && idx_hit) begin
        rdata_q <= index_q;
      end else if (io_rd && dat_hit) begin
        if (index_q == GCR_OFF_LDN) begin
          rdata_q <= ldn_q;
        end else if (index_q == GCR_OFF_ID_HI) begin
          rdata_q <= ID_HIGH;
        end else if (index_q == GCR_OFF_ID_LO) begin
          rdata_q <= {ID_FAMILY, ID_REVISION};
        end else if (index_q == GCR_OFF_PWR) begin
          rdata_q <= pwr_q;
        end else if (index_q == GCR_OFF_IPD) begin
          rdata_q <= ipd_q;
        end else if (index_q == GCR_OFF_OPT) begin
          rdata_q <= opt_view;
        end else if (index_q == GCR_OFF_TRI) begin
          rdata_q <= tri_q;
        end else begin
          rdata_q <= 8'h00; // write-only and unmapped indices
        end
      end
    end
  end

  // outputs are taken straight from the register flops
  assign io_rdata = rdata_q;
  assign io_rvalid = rvalid_q;
  assign soft_reset = swrst_q;
  assign ldn = ldn_q;
  assign hw_monitor_pwr = pwr_q[GCR_B_HWMON];
  assign serial_port_b_pwr = pwr_q[GCR_B_SERB];
  assign serial_port_a_pwr = pwr_q[GCR_B_SERA];
  assign parallel_port_pwr = pwr_q[GCR_B_PAR];
  assign floppy_controller_pwr = pwr_q[GCR_B_FDC];
  assign immediate_power_down = ipd_q[GCR_B_IPD];
  assign cpu_fan_drive_1_od = opt_q[GCR_B_CPUFAN1];
  assign input_clock_rate_select = opt_q[GCR_B_INPUT_CLOCK_RATE_SELECT];
  assign aux_fan_drive_od = opt_q[GCR_B_AUXFAN];
  assign system_fan_drive_pp = opt_q[GCR_B_SYSFAN];
  assign cpu_fan_drive_0_pp = opt_q[GCR_B_CPUFAN0];
  assign serial_flash_en = opt_q[GCR_B_FLASH];
  // strap latches are flops inside the capture block
  assign keyboard_controller_en = ctl.strap_kbc;
  assign config_port_select = ctl.strap_port_sel;
  // a set bit tells that interface's pad ring to float its outputs
  assign serial_b_hiz = tri_q[GCR_B_SERB];
  assign serial_a_hiz = tri_q[GCR_B_SERA];
  assign parallel_hiz = tri_q[GCR_B_PAR];
  assign floppy_hiz = tri_q[GCR_B_FDC];
endmodule // gcr_regs

//--- tb/gcr_regs_monitor.sv
// assertion checker for the global chip control register bank
// assumes single-cycle io strobes and the index/data port pair at base, base+1
`timescale 1ns/1ps
module gcr_regs_monitor
  import gcr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic config_port_select,
  input wire logic soft_reset,
  input wire logic [7:0] ldn,
  input wire logic hw_monitor_pwr,
  input wire logic serial_port_b_pwr,
  input wire logic serial_port_a_pwr,
  input wire logic parallel_port_pwr,
  input wire logic floppy_controller_pwr,
  input wire logic immediate_power_down,
  input wire logic cpu_fan_drive_1_od,
  input wire logic aux_fan_drive_od,
  input wire logic system_fan_drive_pp,
  input wire logic cpu_fan_drive_0_pp,
  input wire logic input_clock_rate_select,
  input wire logic keyboard_controller_en,
  input wire logic serial_flash_en,
  input wire logic serial_b_hiz,
  input wire logic serial_a_hiz,
  input wire logic parallel_hiz,
  input wire logic floppy_hiz
);
  logic [15:0] base;
  logic [7:0] idx_q, wd_q;
  logic key1_q, open_q, idx_wr, dat_wr, rd_hit;
  // the port pair follows the latched strap
  assign base = config_port_select ? GCR_PORT_BASE1 : GCR_PORT_BASE0;
  assign idx_wr = io_wr && io_addr == base;
  assign dat_wr = io_wr && io_addr == base + 16'h0001;
  assign rd_hit = io_rd && (io_addr == base || io_addr == base + 16'h0001);
  // shadow of the unlock state; soft reset is taken not to relock, so the
  // checker may be looser than the design there but never stricter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key1_q <= 1'b0;
      open_q <= 1'b0;
      idx_q <= 8'h00;
      wd_q <= 8'h00;
    end else begin
      wd_q <= io_wdata;
      if (idx_wr) begin
        key1_q <= !open_q && io_wdata == GCR_KEY_ENTER;
        if (open_q) begin
          idx_q <= io_wdata;
        end
        if (io_wdata == GCR_KEY_EXIT) begin
          open_q <= 1'b0;
        end else if (key1_q && io_wdata == GCR_KEY_ENTER) begin
          open_q <= 1'b1;
        end
      end
    end
  end
  sequence s_cfg_wr(logic [7:0] idx);
    open_q && dat_wr && idx_q == idx;
  endsequence
  sequence s_pulse;
    soft_reset ##1 !soft_reset;
  endsequence
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_swrst_fires: assert property (
    s_cfg_wr(GCR_OFF_SWRST) ##0 io_wdata[0] |=> s_pulse) else $error("no reset pulse");
  chk_swrst_cause: assert property (
    soft_reset |-> $past(dat_wr) && wd_q[0]) else $error("stray reset pulse");
  chk_swrst_clears: assert property (
    soft_reset |=> ldn == GCR_RST_LDN && !immediate_power_down && floppy_controller_pwr)
    else $error("soft reset left state");
  chk_ldn_write: assert property (
    s_cfg_wr(GCR_OFF_LDN) |=> ldn == wd_q) else $error("ldn not written");
  chk_ldn_cause: assert property (
    $changed(ldn) |-> $past(dat_wr) || $past(soft_reset)) else $error("ldn changed alone");
  chk_pwr_write: assert property (
    s_cfg_wr(GCR_OFF_PWR) |=> {hw_monitor_pwr, serial_port_b_pwr, serial_port_a_pwr,
    parallel_port_pwr, floppy_controller_pwr} == {wd_q[6:3], wd_q[0]})
    else $error("power bits wrong");
  chk_ipd_write: assert property (
    s_cfg_wr(GCR_OFF_IPD) |=> immediate_power_down == wd_q[0]) else $error("ipd wrong");
  chk_opt_write: assert property (
    s_cfg_wr(GCR_OFF_OPT) |=> {cpu_fan_drive_1_od, input_clock_rate_select,
    aux_fan_drive_od, system_fan_drive_pp, cpu_fan_drive_0_pp, serial_flash_en}
    == {wd_q[7:3], wd_q[1]}) else $error("option bits wrong");
  chk_kbc_readonly: assert property (
    s_cfg_wr(GCR_OFF_OPT) |=> $stable(keyboard_controller_en)) else $error("kbc written");
  chk_tri_write: assert property (
    s_cfg_wr(GCR_OFF_TRI) |=> {serial_b_hiz, serial_a_hiz, parallel_hiz, floppy_hiz}
    == {wd_q[5:3], wd_q[0]}) else $error("tri-state bits wrong");
  chk_read_answer: assert property (
    rd_hit |=> io_rvalid) else $error("read not answered");
  chk_locked_read: assert property (
    !open_q && io_rd && io_addr == base + 16'h0001 |=> io_rdata == GCR_RD_IDLE)
    else $error("locked read not idle");
endmodule // gcr_regs_monitor

bind gcr_regs gcr_regs_monitor u_monitor (.*);

//--- tb/gcr_regs_tb.sv
// self-checking bench for the global chip control register bank
// assumes keyboard and flash straps high; port strap low until the reset scenario
`timescale 1ns/1ps
module gcr_regs_tb;
  import gcr_pkg::*;
  localparam logic [7:0] ID_H = 8'h5A; // arbitrary identity value
  localparam logic [3:0] ID_F = 4'h3; // arbitrary identity value
  localparam logic [3:0] ID_R = 4'h1; // arbitrary revision value
  localparam logic [15:0] IDX = GCR_PORT_BASE0;
  localparam logic [15:0] DAT = GCR_PORT_BASE0 + 16'h0001;
  logic clk, nrst, io_wr, io_rd, io_rvalid, soft_reset, ext_lvl;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, ldn;
  logic strap_kbc_pin, strap_flash_pin, strap_port_sel_pin, config_port_select;
  logic hw_monitor_pwr, serial_port_b_pwr, serial_port_a_pwr, parallel_port_pwr;
  logic floppy_controller_pwr, immediate_power_down, cpu_fan_drive_1_od;
  logic aux_fan_drive_od, system_fan_drive_pp, cpu_fan_drive_0_pp;
  logic input_clock_rate_select, keyboard_controller_en, serial_flash_en;
  logic serial_b_hiz, serial_a_hiz, parallel_hiz, floppy_hiz;
  logic flash_sck, flash_ce_n, flash_dout, beep, gpio_23_out, gpio_23_oe;
  logic gpio_22_out, gpio_22_oe, gpio_23_in, gpio_22_in, aux_fan_tach_in, flash_din;
  logic pin2_in, pin2_out, pin2_oe, pin19_in, pin19_out, pin19_oe;
  logic pin58_in, pin118_out, pin118_oe;
  int n_mismatch, n_checks;
  // pad level: the design's driver wins, otherwise the board level
  assign pin2_in = pin2_oe ? pin2_out : ext_lvl;
  assign pin19_in = pin19_oe ? pin19_out : ext_lvl;
  gcr_regs #(.ID_HIGH(ID_H), .ID_FAMILY(ID_F), .ID_REVISION(ID_R)) DUT (.*);
  // output bits laid out as in their registers
  function automatic logic [7:0] pwr_pins();
    return {1'b1, hw_monitor_pwr, serial_port_b_pwr, serial_port_a_pwr,
      parallel_port_pwr, 2'b11, floppy_controller_pwr};
  endfunction
  function automatic logic [7:0] opt_pins();
    return {cpu_fan_drive_1_od, input_clock_rate_select, aux_fan_drive_od,
      system_fan_drive_pp, cpu_fan_drive_0_pp, keyboard_controller_en, serial_flash_en, 1'b0};
  endfunction
  function automatic logic [7:0] tri_pins();
    return {2'b00, serial_b_hiz, serial_a_hiz, parallel_hiz, 2'b00, floppy_hiz};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic io_w(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask
  // the answer stands exactly one cycle after the read edge
  task automatic io_r(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    chkb(io_rvalid, 1'b1);
    d = io_rdata;
  endtask
  task automatic unlock(input logic [15:0] a = IDX);
    io_w(a, GCR_KEY_ENTER);
    io_w(a, GCR_KEY_ENTER);
  endtask
  task automatic cfg_w(input logic [7:0] idx, input logic [7:0] d);
    io_w(IDX, idx);
    io_w(DAT, d);
  endtask
  task automatic cfg_c(input logic [7:0] idx, exp, input logic [15:0] a = IDX);
    logic [7:0] v;
    io_w(a, idx);
    io_r(a + 16'h0001, v);
    chk(v, exp);
  endtask
  task automatic t_defaults();
    logic [7:0] v;
    io_r(DAT, v);
    chk(v, GCR_RD_IDLE);
    unlock();
    cfg_c(GCR_OFF_LDN, 8'h00);
    cfg_c(GCR_OFF_ID_HI, ID_H);
    cfg_c(GCR_OFF_ID_LO, {ID_F, ID_R});
    cfg_c(GCR_OFF_PWR, 8'hFF);
    cfg_c(GCR_OFF_IPD, 8'h00);
    cfg_c(GCR_OFF_OPT, 8'h46);
    cfg_c(GCR_OFF_TRI, 8'h00);
    chk(opt_pins(), 8'h46);
  endtask
  task automatic t_pins_flash();
    @(posedge clk);
    flash_sck <= 1'b1;
    flash_ce_n <= 1'b0;
    flash_dout <= 1'b1;
    pin58_in <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({pin2_out, pin2_oe, pin19_out, pin19_oe, pin118_out, pin118_oe, flash_din,
      aux_fan_tach_in}, 8'hDE);
  endtask
  task automatic t_regs();
    cfg_w(GCR_OFF_LDN, 8'hA5);
    cfg_c(GCR_OFF_LDN, 8'hA5);
    cfg_w(GCR_OFF_PWR, 8'h00);
    cfg_c(GCR_OFF_PWR, 8'h86);
    chk(pwr_pins(), 8'h86);
    cfg_w(GCR_OFF_PWR, 8'hFF);
    cfg_w(GCR_OFF_IPD, 8'hFF);
    cfg_c(GCR_OFF_IPD, 8'h01);
    chk({4'h0, immediate_power_down, pin2_oe, pin19_oe, pin118_oe}, 8'h08);
    cfg_w(GCR_OFF_IPD, 8'h00);
    cfg_w(GCR_OFF_OPT, 8'hFF);
    cfg_c(GCR_OFF_OPT, 8'hFE);
    chk(opt_pins(), 8'hFE);
    cfg_w(GCR_OFF_OPT, 8'h00);
    cfg_c(GCR_OFF_OPT, 8'h04);
    chk(opt_pins(), 8'h04);
    cfg_w(GCR_OFF_TRI, 8'hFF);
    cfg_c(GCR_OFF_TRI, 8'h39);
    chk(tri_pins(), 8'h39);
    cfg_w(GCR_OFF_TRI, 8'h00);
    cfg_c(GCR_OFF_TRI, 8'h00);
    chk(tri_pins(), 8'h00);
    cfg_w(GCR_OFF_ID_HI, 8'h00);
    cfg_c(GCR_OFF_ID_HI, ID_H);
    cfg_w(GCR_OFF_ID_LO, 8'h00);
    cfg_c(GCR_OFF_ID_LO, {ID_F, ID_R});
    cfg_c(GCR_OFF_SWRST, 8'h00);
    cfg_c(8'h30, 8'h00);
  endtask
  task automatic t_pins_gpio();
    @(posedge clk);
    flash_sck <= 1'b0;
    flash_dout <= 1'b0;
    beep <= 1'b1;
    gpio_23_out <= 1'b1;
    gpio_23_oe <= 1'b0;
    gpio_22_out <= 1'b1;
    gpio_22_oe <= 1'b1;
    ext_lvl <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({pin2_oe, pin19_out, pin19_oe, pin118_out, gpio_23_in, gpio_22_in,
      aux_fan_tach_in, flash_din}, 8'h7E);
  endtask
  task automatic t_swrst();
    logic [7:0] wd [3] = '{8'h01, 8'hFE, 8'h01};
    int n;
    for (int k = 0; k < 3; k++) begin
      cfg_w(GCR_OFF_LDN, 8'h33);
      cfg_w(GCR_OFF_SWRST, wd[k]);
      #1;
      n = soft_reset;
      repeat (3) begin
        @(posedge clk);
        #1;
        n += soft_reset;
      end
      chk(8'(n), {7'h00, wd[k][0]});
      io_w(IDX, GCR_KEY_EXIT);
      unlock();
      cfg_c(GCR_OFF_LDN, wd[k][0] ? 8'h00 : 8'h33);
    end
    chkb(serial_flash_en, 1'b1);
  endtask
  task automatic t_lock();
    logic [7:0] v;
    io_w(IDX, GCR_KEY_EXIT);
    io_w(DAT, 8'h77);
    io_r(DAT, v);
    chk(v, GCR_RD_IDLE);
    io_w(IDX, GCR_KEY_ENTER);
    io_w(IDX, GCR_OFF_LDN);
    io_w(IDX, GCR_KEY_ENTER);
    io_r(DAT, v);
    chk(v, GCR_RD_IDLE);
    unlock();
    cfg_c(GCR_OFF_LDN, 8'h00);
  endtask
  task automatic t_hwreset();
    cfg_w(GCR_OFF_LDN, 8'h5C);
    @(posedge clk);
    nrst <= 1'b0;
    strap_port_sel_pin <= 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(ldn, GCR_RST_LDN);
    chk(pwr_pins(), GCR_RST_PWR);
    chkb(keyboard_controller_en, 1'b1);
    chkb(config_port_select, 1'b1);
    unlock(GCR_PORT_BASE1);
    cfg_c(GCR_OFF_ID_HI, ID_H, GCR_PORT_BASE1);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // a hang is cut short well past the few hundred cycles the run needs
  initial begin
    #40000;
    n_mismatch++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    {io_wr, io_rd, io_addr, io_wdata} = '0;
    {strap_kbc_pin, strap_flash_pin, strap_port_sel_pin} = 3'b110;
    {flash_sck, flash_ce_n, flash_dout, beep, pin58_in, ext_lvl} = '0;
    {gpio_23_out, gpio_23_oe, gpio_22_out, gpio_22_oe} = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    t_defaults();
    t_pins_flash();
    t_regs();
    t_pins_gpio();
    t_swrst();
    t_lock();
    t_hwreset();
    close_out();
  end
endmodule // gcr_regs_tb
